// >>> flp_fault_latch.sv
// Protection management of a point-of-load regulator: fault latches,
// restart timing, turn-off style and the shared fault line.
// Assumes vout and target in mV on this clock; flags arrive as pins.
// Operation
// - High-voltage check armed only above bias
// - High-voltage error stops output, clears flag bit
// - Emergency: high side off, low side on
// - High-voltage limit 110..130 percent, floor 0.5V
// - High-voltage limit at least 0.25V above target
// - Limits scale with nominal or margin target
// - Per-fault latching and propagation choice
// - Auto-retry restarts every 130ms until cleared
// - Restart ramps through tracking and sequencing
// - Latched fault waits 130ms plus clear
// - Policy register at 0x00, enables bits 7:6
// - Policy bits 5:0 select latching per fault
// - Styles selectable for thermal, low voltage; high voltage for peers only
// - Sequenced style ramps down at set rate
// - Critical style turns both switches off
// - Flags register at 0x16 with fixed map
// - Active fault reads as zero
// - Writing one clears latched fault
// - Propagating fault pulls shared line low
// - Low shared line turns off with same style
// - Style coded on line's falling transition
// - Line changes only at sync line falling edge
// - Thermal and low-voltage: sequenced or critical
`timescale 1ns/1ns
module flp_fault_latch
   import flp_pkg::*;
#(
   parameter int RETRY_CNT = RETRY_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_q,
   input wire logic [15:0] vout_mv,
   input wire logic [15:0] bias_mv,
   input wire logic [15:0] target_mv,
   input wire logic [4:0] hv_pct_add,
   input wire logic [7:0] lv_pct,
   input wire logic [5:0] prop_en,
   input wire logic therm_crit_sel,
   input wire logic lowv_crit_sel,
   input wire logic highv_emer_sel,
   input wire logic on_cmd,
   input wire logic steady,
   input wire logic therm_hot,
   input wire logic curr_over,
   input wire logic follow_err,
   input wire logic phase_err,
   input wire logic heat_warn,
   input wire logic window_bad,
   input wire logic sync_line,
   input wire logic fault_line_i,
   output logic fault_line_o_q,
   output logic fault_line_oe_q,
   output logic run_q,
   output logic [1:0] off_style_q,
   output logic ramp_start_q
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam int NS = 10;
   logic [NS-1:0] pin_raw;
   logic [NS-1:0] s1_q;
   logic [NS-1:0] s2_q;
   assign pin_raw = {fault_line_i, sync_line, on_cmd, steady, therm_hot,
                     curr_over, follow_err, phase_err, heat_warn, window_bad};
   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         // Stage one feeds only stage two
         always_ff @(posedge sys_clk) begin
            s1_q[gi] <= rst_n ? pin_raw[gi] : 1'b0;
            s2_q[gi] <= rst_n ? s1_q[gi] : 1'b0;
         end
      end
   endgenerate
   logic line_s, sd_s, on_s, steady_s, hot_s, curr_s;
   logic follow_s, phase_s, heat_s, window_s;
   assign {line_s, sd_s, on_s, steady_s, hot_s, curr_s, follow_s, phase_s,
           heat_s, window_s} = s2_q;

   // ----------------------------------------
   // Thresholds
   // ----------------------------------------
   logic [7:0] hv_pct;
   logic [23:0] hv_prod, lv_prod;
   logic [15:0] hv_pct_mv, hv_lim, lv_lim, tgt_pad;
   // Target already tracks margining, so limits follow it
   always_comb begin
      hv_pct = HV_PCT_MIN + {3'h0, hv_pct_add};
      if (hv_pct > HV_PCT_MAX) begin
         hv_pct = HV_PCT_MAX;
      end
      hv_prod = target_mv * hv_pct;
      hv_pct_mv = 16'(hv_prod / PCT_FULL);
      tgt_pad = target_mv + HV_MARGIN_MV;
      hv_lim = hv_pct_mv;
      if (hv_lim < tgt_pad) begin
         hv_lim = tgt_pad;
      end
      if (hv_lim < HV_FLOOR_MV) begin
         hv_lim = HV_FLOOR_MV;
      end
      lv_prod = target_mv * lv_pct;
      lv_lim = 16'(lv_prod / PCT_FULL);
   end

   // ----------------------------------------
   // Policy register and detection
   // ----------------------------------------
   logic [7:0] policy_q, policy_d;
   logic [5:0] det;
   logic wr_pol, wr_flg;
   assign wr_pol = reg_wr && (reg_addr == POLICY_ADDR);
   assign wr_flg = reg_wr && (reg_addr == FLAGS_ADDR);
   always_comb begin
      policy_d = wr_pol ? reg_wdata : policy_q;
      det[F_FOLLOW] = follow_s && policy_q[FOLLOW_EN_BIT];
      det[F_PHASE] = phase_s && policy_q[PHASE_EN_BIT];
      det[F_THERM] = hot_s;
      det[F_CURR] = curr_s;
      // Steady only, so ramps never trip it
      det[F_LOWV] = steady_s && (vout_mv < lv_lim);
      // Armed only above any pre-bias
      det[F_HIGHV] = (vout_mv > bias_mv) && (vout_mv > hv_lim);
   end
   always_ff @(posedge sys_clk) begin
      policy_q <= rst_n ? policy_d : POLICY_RST;
   end

   // ----------------------------------------
   // Style per fault
   // ----------------------------------------
   logic [1:0] loc_sty [6];
   logic [1:0] net_sty [6];
   logic [1:0] loc_max, net_max, det_max;
   logic [5:0] flt_q, flt_d, sent;
   always_comb begin
      loc_sty[F_FOLLOW] = STY_CRIT;
      loc_sty[F_CURR] = STY_CRIT;
      loc_sty[F_PHASE] = STY_CRIT;
      // Thermal and low voltage pick sequenced or critical
      loc_sty[F_THERM] = therm_crit_sel ? STY_CRIT : STY_SEQ;
      loc_sty[F_LOWV] = lowv_crit_sel ? STY_CRIT : STY_SEQ;
      loc_sty[F_HIGHV] = STY_EMER;
      net_sty = loc_sty;
      // Own stage always clamps; peers get the chosen code
      net_sty[F_HIGHV] = highv_emer_sel ? STY_EMER : STY_CRIT;
      sent = flt_q & prop_en;
      loc_max = STY_NONE;
      net_max = STY_NONE;
      det_max = STY_NONE;
      for (int i = 0; i < 6; i++) begin
         if (flt_q[i] && loc_sty[i] > loc_max) loc_max = loc_sty[i];
         if (det[i] && loc_sty[i] > det_max) det_max = loc_sty[i];
         if (sent[i] && net_sty[i] > net_max) net_max = net_sty[i];
      end
   end

   // ----------------------------------------
   // Shared fault line, sync line edges
   // ----------------------------------------
   logic sd_last_q, rx_last_q, sd_fall, sd_rise;
   logic [2:0] tx_ph_q, tx_ph_d;
   logic [1:0] tx_sty_q, tx_sty_d, rx_sty_q, rx_sty_d;
   logic [1:0] rx_ph_q, rx_ph_d;
   logic oe_d, rx_last_d, ext_act;
   assign sd_fall = sd_last_q && !sd_s;
   assign sd_rise = !sd_last_q && sd_s;
   assign ext_act = (rx_ph_q == 2'h3);
   // Frame: low, style bit 1, style bit 0, then held low
   always_comb begin
      tx_ph_d = tx_ph_q;
      tx_sty_d = tx_sty_q;
      oe_d = fault_line_oe_q;
      if (sd_fall) begin
         case (tx_ph_q)
            3'h0: begin
               if (|sent) begin
                  tx_ph_d = 3'h1;
                  tx_sty_d = net_max;
                  oe_d = 1'b1;
               end
            end
            3'h1: begin
               tx_ph_d = 3'h2;
               oe_d = ~tx_sty_q[1];
            end
            3'h2: begin
               tx_ph_d = 3'h3;
               oe_d = ~tx_sty_q[0];
            end
            3'h3: begin
               tx_ph_d = 3'h4;
               oe_d = 1'b1;
            end
            default: begin
               if (!(|sent)) begin
                  tx_ph_d = 3'h0;
                  oe_d = 1'b0;
               end
            end
         endcase
      end
      // Receiver samples on the rising edge, mid-bit
      rx_ph_d = rx_ph_q;
      rx_sty_d = rx_sty_q;
      rx_last_d = rx_last_q;
      if (sd_rise) begin
         rx_last_d = line_s;
         case (rx_ph_q)
            2'h0: if (rx_last_q && !line_s) rx_ph_d = 2'h1;
            2'h1: begin
               rx_sty_d[1] = line_s;
               rx_ph_d = 2'h2;
            end
            2'h2: begin
               rx_sty_d = {rx_sty_q[1], line_s};
               rx_ph_d = 2'h3;
               // Unused code 00 falls back to critical
               if (!rx_sty_q[1] && !line_s) rx_sty_d = STY_CRIT;
            end
            default: if (line_s) rx_ph_d = 2'h0;
         endcase
      end
   end
   always_ff @(posedge sys_clk) begin
      sd_last_q <= rst_n ? sd_s : 1'b0;
      rx_last_q <= rst_n ? rx_last_d : 1'b1;
      tx_ph_q <= rst_n ? tx_ph_d : 3'h0;
      tx_sty_q <= rst_n ? tx_sty_d : STY_NONE;
      rx_ph_q <= rst_n ? rx_ph_d : 2'h0;
      rx_sty_q <= rst_n ? rx_sty_d : STY_NONE;
      fault_line_oe_q <= rst_n ? oe_d : 1'b0;
      fault_line_o_q <= 1'b0;
   end

   // ----------------------------------------
   // Restart state machine and latches
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ON = 2'h1,
      ST_WAIT = 2'h3
   } flp_state_e;
   flp_state_e st_q, st_d;
   logic [24:0] tmr_q, tmr_d;
   logic [1:0] sty_d;
   logic run_d, ramp_d, blocked, tmr_done;
   logic [5:0] clr;
   assign tmr_done = (tmr_q == 25'(RETRY_CNT - 1));
   // Auto-retry waits only for causes; latched ones need a clear
   assign blocked = (|det) || (|(flt_q & policy_q[5:0])) || ext_act;
   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q;
      sty_d = off_style_q;
      run_d = run_q;
      ramp_d = 1'b0;
      // Write one clears, zero leaves it, reserved ignored
      clr = wr_flg ? (reg_wdata[5:0] & CLEARABLE) : 6'h00;
      case (st_q)
         ST_IDLE: begin
            clr = 6'h3f; // Command low clears latches
            sty_d = STY_NONE;
            if (on_s) begin
               st_d = ST_ON;
               run_d = 1'b1;
               ramp_d = 1'b1;
            end
         end
         ST_ON: begin
            if (|det || ext_act) begin
               st_d = ST_WAIT;
               tmr_d = '0;
               run_d = 1'b0;
               // Most severe wins; peers follow coded style
               sty_d = (det_max > rx_sty_q || !ext_act) ? det_max : rx_sty_q;
               if (det_max == STY_NONE) sty_d = rx_sty_q;
            end else if (!on_s) begin
               st_d = ST_IDLE;
               run_d = 1'b0;
            end
         end
         default: begin
            tmr_d = tmr_q + 25'h1;
            if (!on_s) begin
               st_d = ST_IDLE;
            end else if (tmr_done) begin
               tmr_d = '0;
               if (!blocked) begin
                  st_d = ST_ON;
                  run_d = 1'b1;
                  ramp_d = 1'b1;
                  sty_d = STY_NONE;
                  clr = clr | ~policy_q[5:0];
               end
            end
         end
      endcase
      // Set wins over clear; active shows as zero on read
      flt_d = (flt_q & ~clr) | det;
   end
   // Style drives stage: seq ramps crit both off
   always_ff @(posedge sys_clk) begin
      st_q <= rst_n ? st_d : ST_IDLE;
      tmr_q <= rst_n ? tmr_d : 25'h0;
      flt_q <= rst_n ? flt_d : 6'h00;
      run_q <= rst_n ? run_d : 1'b0;
      ramp_start_q <= rst_n ? ramp_d : 1'b0;
      off_style_q <= rst_n ? sty_d : STY_NONE;
   end

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   logic [7:0] flags, rdata_d;
   always_comb begin
      flags = {~heat_s, ~window_s, ~flt_q[5:1], 1'b0};
      rdata_d = reg_rdata_q;
      if (reg_rd) begin
         if (reg_addr == POLICY_ADDR) rdata_d = policy_q;
         else if (reg_addr == FLAGS_ADDR) rdata_d = flags;
         else rdata_d = 8'h00;
      end
   end
   always_ff @(posedge sys_clk) begin
      reg_rdata_q <= rst_n ? rdata_d : 8'h00;
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_high_trip: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st_q == ST_ON && det[F_HIGHV] |=> st_q == ST_WAIT && !run_q
      && off_style_q == STY_EMER) else $error("high trip missed");
   a_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
      det[F_HIGHV] && wr_flg && reg_wdata[1] |=> flt_q[F_HIGHV])
      else $error("set lost to clear");
   a_one_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st_q == ST_ON && wr_flg && reg_wdata[3] && !det[F_CURR]
      |=> !flt_q[F_CURR]) else $error("clear ignored");
   a_zero_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
      st_q == ST_ON && wr_flg && reg_wdata == 8'h00
      |=> (flt_q & $past(flt_q)) == $past(flt_q)) else $error("zero cleared");
   a_line_edge: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fault_line_oe_q != $past(fault_line_oe_q) |-> $past(sd_fall))
      else $error("line moved off edge");
   a_policy_rw: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_pol ##1 reg_rd && reg_addr == POLICY_ADDR
      |=> reg_rdata_q == $past(reg_wdata, 2)) else $error("policy readback");
   a_retry_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(st_q == ST_WAIT) |-> !ramp_start_q [*8]) else $error("early restart");
   a_ramp_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ramp_start_q |-> run_q && st_q == ST_ON && $past(st_q) != ST_ON)
      else $error("ramp without start");
endmodule

// >>> flp_pkg.sv
// Constants of the fault latch and propagation logic.
// Assumes one 250 MHz clock and an 8-bit register port.
package flp_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] POLICY_ADDR = 8'h00;
   localparam logic [7:0] FLAGS_ADDR = 8'h16;
   localparam logic [7:0] POLICY_RST = 8'h00;
   localparam int FOLLOW_EN_BIT = 7;
   localparam int PHASE_EN_BIT = 6;
   localparam int HEAT_BIT = 7;
   localparam int WINDOW_BIT = 6;
   // Fault index = latch select bit = flag bit, except phase: flag bit 0 always reads zero
   localparam int F_FOLLOW = 5;
   localparam int F_THERM = 4;
   localparam int F_CURR = 3;
   localparam int F_LOWV = 2;
   localparam int F_HIGHV = 1;
   localparam int F_PHASE = 0;
   localparam logic [5:0] CLEARABLE = 6'h3e;
   // ----------------------------------------
   // Turn-off styles, ordered by severity
   // ----------------------------------------
   typedef enum logic [1:0] {
      STY_NONE = 2'h0,
      STY_SEQ = 2'h1,
      STY_CRIT = 2'h2,
      STY_EMER = 2'h3
   } flp_style_e;
   // ----------------------------------------
   // Thresholds (millivolts, percent)
   // ----------------------------------------
   localparam logic [15:0] HV_FLOOR_MV = 16'h01f4;
   localparam logic [15:0] HV_MARGIN_MV = 16'h00fa;
   localparam logic [7:0] HV_PCT_MIN = 8'h6e;
   localparam logic [7:0] HV_PCT_MAX = 8'h82;
   localparam logic [7:0] PCT_FULL = 8'h64;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 250;
   localparam int RETRY_MS = 130;
   localparam int RETRY_CYC = RETRY_MS * 1000 * CLK_MHZ;
endpackage

// >>> flp_peer_model.sv
// Partner model: free-running sync source of the manager and one peer
// regulator on the wired shared fault line.
// Assumes the regulator's pull-down enable and the same clock as the bench.
`timescale 1ns/1ns
module flp_peer_model #(
   parameter int HALF = 4
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic dut_oe,
   input wire logic send,
   input wire logic [1:0] style,
   output logic sync_line,
   output logic fault_line
);
   logic [7:0] cnt_q = 8'h00;
   logic [2:0] st_q = 3'h0;
   logic [2:0] nxt;
   logic oe_q = 1'b0;
   logic wrap;
   // ----------------------------------------
   // Sync line and peer frame
   // ----------------------------------------
   // One driver for the sync output; the register starts low
   logic sync_q = 1'b0;
   assign sync_line = sync_q;
   assign wrap = cnt_q == 8'(HALF - 1);
   // Frame: start low, style MSB, style LSB, then low while told to hold
   always_comb begin
      nxt = st_q + 3'h1;
      if (st_q == 3'h0) nxt = {2'b00, send};
      if (st_q == 3'h4) nxt = send ? 3'h4 : 3'h0;
   end
   // Sync runs free, even in reset, since the manager owns it
   always @(posedge sys_clk) begin
      cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
      if (wrap) sync_q <= ~sync_q;
      if (!rst_n) begin
         st_q <= 3'h0;
         oe_q <= 1'b0;
      end else if (wrap && sync_q) begin
         st_q <= nxt;
         oe_q <= (nxt == 3'h2) ? ~style[1] : (nxt == 3'h3) ? ~style[0] : nxt != 3'h0;
      end
   end
   // Pull-up: the line is high unless someone pulls it low
   assign fault_line = ~(oe_q | dut_oe);
endmodule

// >>> testbench.sv
// Self-checking bench of the fault latch and propagation logic.
// Assumes the partner model for sync and the shared line, short retry count.
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench
   import flp_pkg::*;
;
   typedef struct {
      logic [5:0] pins;
      logic [15:0] vout;
      logic [15:0] bias;
      logic [15:0] tgt;
      logic [4:0] hva;
      logic [1:0] crit;
      flp_style_e st;
      logic [7:0] fl;
   } flp_tb_row_s;
   localparam flp_tb_row_s NOM = '{6'h00, 16'h03e8, 16'h0000, 16'h03e8, 5'h00, 2'h0, STY_NONE, 8'hfe};
   // ----------------------------------------
   // Ordinary cases: pins {window,heat,phase,follow,curr,therm}
   // ----------------------------------------
   flp_tb_row_s rows [17] = '{
      '{6'h01, 16'h03e8, 16'h0000, 16'h03e8, 5'h00, 2'h0, STY_SEQ, 8'hee},
      '{6'h01, 16'h03e8, 16'h0000, 16'h03e8, 5'h00, 2'h1, STY_CRIT, 8'hee},
      '{6'h02, 16'h03e8, 16'h0000, 16'h03e8, 5'h00, 2'h0, STY_CRIT, 8'hf6},
      '{6'h04, 16'h03e8, 16'h0000, 16'h03e8, 5'h00, 2'h0, STY_CRIT, 8'hde},
      '{6'h08, 16'h03e8, 16'h0000, 16'h03e8, 5'h00, 2'h0, STY_CRIT, 8'hfe},
      '{6'h00, 16'h0320, 16'h0000, 16'h03e8, 5'h00, 2'h0, STY_SEQ, 8'hfa},
      '{6'h00, 16'h0320, 16'h0000, 16'h03e8, 5'h00, 2'h2, STY_CRIT, 8'hfa},
      '{6'h00, 16'h0514, 16'h0000, 16'h03e8, 5'h00, 2'h0, STY_EMER, 8'hfc},
      '{6'h00, 16'h04d8, 16'h0000, 16'h03e8, 5'h00, 2'h0, STY_NONE, 8'hfe},
      '{6'h00, 16'h050a, 16'h0000, 16'h03e8, 5'h14, 2'h0, STY_NONE, 8'hfe},
      '{6'h00, 16'h051e, 16'h0000, 16'h03e8, 5'h14, 2'h0, STY_EMER, 8'hfc},
      '{6'h00, 16'h051e, 16'h0000, 16'h03e8, 5'h1f, 2'h0, STY_EMER, 8'hfc},
      '{6'h00, 16'h0578, 16'h05dc, 16'h03e8, 5'h00, 2'h0, STY_NONE, 8'hfe},
      '{6'h00, 16'h03b6, 16'h0000, 16'h044c, 5'h00, 2'h0, STY_SEQ, 8'hfa},
      '{6'h00, 16'h0208, 16'h0000, 16'h00c8, 5'h00, 2'h0, STY_EMER, 8'hfc},
      '{6'h10, 16'h03e8, 16'h0000, 16'h03e8, 5'h00, 2'h0, STY_NONE, 8'h7e},
      '{6'h20, 16'h03e8, 16'h0000, 16'h03e8, 5'h00, 2'h0, STY_NONE, 8'hbe}};
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q;
   logic [15:0] vout_mv = 16'h03e8, bias_mv = 16'h0000, target_mv = 16'h03e8;
   logic [4:0] hv_pct_add = 5'h00;
   logic [5:0] prop_en = 6'h00;
   logic therm_crit_sel = 1'b0, lowv_crit_sel = 1'b0, on_cmd = 1'b0;
   logic therm_hot = 1'b0, curr_over = 1'b0, follow_err = 1'b0, phase_err = 1'b0;
   logic heat_warn = 1'b0, window_bad = 1'b0, send = 1'b0, sync_line, fault_line;
   logic [1:0] style = 2'h0, off_style_q;
   logic fault_line_o_q, fault_line_oe_q, run_q, ramp_start_q;
   logic ramp_seen = 1'b0, sync_p = 1'b0, oe_p = 1'b0, b1, b0;
   int error_cnt = 0, check_count = 0, since = 0, n, k;
   // Short retry count keeps the hiccup tests to a few hundred cycles
   flp_fault_latch #(.RETRY_CNT(50)) i_dut (.sys_clk, .rst_n, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata_q, .vout_mv, .bias_mv, .target_mv, .hv_pct_add,
      .lv_pct(8'h5a), .prop_en, .therm_crit_sel, .lowv_crit_sel, .highv_emer_sel(1'b1),
      .on_cmd, .steady(1'b1), .therm_hot, .curr_over, .follow_err, .phase_err, .heat_warn,
      .window_bad, .sync_line, .fault_line_i(fault_line), .fault_line_o_q,
      .fault_line_oe_q, .run_q, .off_style_q, .ramp_start_q);
   flp_peer_model i_peer (.sys_clk, .rst_n, .dut_oe(fault_line_oe_q), .send, .style,
      .sync_line, .fault_line);
   always #2 sys_clk = ~sys_clk;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Sampled at the falling clock edge, where everything has settled
   always @(negedge sys_clk) begin
      if (sync_p && !sync_line) since = 0;
      else since++;
      if (oe_p !== fault_line_oe_q) `CHK(since < 6, 1'b1)
      sync_p = sync_line;
      oe_p = fault_line_oe_q;
   end
   // The one-cycle ramp pulse is caught here, just after every rising edge
   task tick(input int c);
      repeat (c) begin
         @(posedge sys_clk);
         #1;
         if (ramp_start_q === 1'b1) ramp_seen = 1'b1;
      end
   endtask
   task wrap_up();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task tmo();
      `CHK(1'b0, 1'b1)
      wrap_up();
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
   endtask
   task rd(input logic [7:0] a);
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      tick(1);
   endtask
   // Bounded wait for the run output; n returns the cycles spent
   task wait_run(input logic v, input int lim);
      for (n = 0; n < lim && run_q !== v; n++) tick(1);
      if (n == lim) tmo();
   endtask
   // Line level at the next rise of the sync line
   task rise(output logic lvl);
      logic p;
      p = sync_line;
      tick(1);
      for (k = 0; k < 20 && !(!p && sync_line); k++) begin
         p = sync_line;
         tick(1);
      end
      if (k == 20) tmo();
      lvl = fault_line;
   endtask
   task apply(input flp_tb_row_s r);
      {window_bad, heat_warn, phase_err, follow_err, curr_over, therm_hot} = r.pins;
      vout_mv = r.vout;
      bias_mv = r.bias;
      target_mv = r.tgt;
      hv_pct_add = r.hva;
      {lowv_crit_sel, therm_crit_sel} = r.crit;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      tick(6);
      rst_n = 1'b1;
      `CHK({run_q, off_style_q, fault_line_oe_q, fault_line_o_q}, 5'h00)
      rd(POLICY_ADDR);
      `CHK(reg_rdata_q, POLICY_RST)
      rd(FLAGS_ADDR);
      `CHK(reg_rdata_q, 8'hfe)
      wr(8'h05, 8'hff);
      rd(8'h05);
      `CHK(reg_rdata_q, 8'h00)
      wr(POLICY_ADDR, 8'hc0);
      rd(POLICY_ADDR);
      `CHK(reg_rdata_q, 8'hc0)
      on_cmd = 1'b1;
      wait_run(1'b1, 50);
      `CHK(ramp_seen, 1'b1)
      // Each row trips or spares the stage; auto-retry must restart only a tripped one
      foreach (rows[i]) begin
         apply(rows[i]);
         tick(6);
         `CHK(run_q, rows[i].st == STY_NONE)
         `CHK(off_style_q, rows[i].st)
         rd(FLAGS_ADDR);
         `CHK(reg_rdata_q, rows[i].fl)
         apply(NOM);
         ramp_seen = 1'b0;
         wait_run(1'b1, 200);
         `CHK(n > 35, rows[i].st != STY_NONE)
         `CHK(ramp_seen, rows[i].st != STY_NONE)
         tick(4);
         rd(FLAGS_ADDR);
         `CHK({reg_rdata_q, off_style_q}, {8'hfe, STY_NONE})
      end
      // Latched thermal fault, propagated with its style on the line
      wr(POLICY_ADDR, 8'hd0);
      prop_en = 6'h10;
      therm_crit_sel = 1'b1;
      therm_hot = 1'b1;
      for (k = 0; k < 100 && fault_line !== 1'b0; k++) tick(1);
      if (k == 100) tmo();
      rise(b1);
      `CHK(b1, 1'b0)
      rise(b1);
      rise(b0);
      `CHK({b1, b0}, 2'h2)
      therm_hot = 1'b0;
      tick(80);
      `CHK({run_q, fault_line}, 2'h0)
      wr(FLAGS_ADDR, 8'h01);
      rd(FLAGS_ADDR);
      `CHK(reg_rdata_q, 8'hee)
      wr(FLAGS_ADDR, 8'h10);
      wait_run(1'b1, 300);
      `CHK(fault_line, 1'b1)
      // Styles announced by a peer are taken over as received
      prop_en = 6'h00;
      for (int s = 1; s < 4; s++) begin
         style = 2'(s);
         send = 1'b1;
         wait_run(1'b0, 100);
         `CHK(off_style_q, flp_style_e'(s))
         send = 1'b0;
         wait_run(1'b1, 300);
      end
      wrap_up();
   end
endmodule
